// file: pkg/mes_pkg.sv
// Package: register map, field layout and bus types of the MAC event status block
package mes_pkg;
  localparam logic [7:0]  MES_STATUS_OFFSET = 8'h00;
  localparam logic [7:0]  MES_ENABLE_OFFSET = 8'h04;
  localparam logic [7:0]  MES_DMA_OFFSET    = 8'h08;
  localparam logic [7:0]  MES_CTRL_OFFSET   = 8'h0c;
  localparam int          MES_PAUSE_BIT     = 4;
  localparam int          MES_LINK_BIT      = 2;
  localparam int          MES_MAGIC_BIT     = 1;
  localparam int          MES_CARRIER_BIT   = 0;
  localparam int          MES_SUMMARY_BIT   = 0;
  localparam int          MES_FLOW_EN_BIT   = 0;
  localparam logic [31:0] MES_FIELD_MASK    = 32'h0000_0017;
  localparam logic [31:0] MES_RESET_VALUE   = 32'h0000_0000;
  localparam logic [1:0]  MES_RESP_OKAY     = 2'h0;
  localparam logic [1:0]  MES_RESP_SLVERR   = 2'h2;

  typedef struct packed {
    logic pause_retry_over;
    logic link_status;
    logic magic_packet;
    logic illegal_carrier;
  } mes_events_t;
endpackage : mes_pkg

// file: rtl/mes_pin_sync.sv
// Three-stage synchroniser with agreement filter for a PHY pin
`timescale 1ns/1ns
module mes_pin_sync
  import mes_pkg::*;
(
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic pin,
  output logic      level
);
  logic s1;
  logic s2;
  logic s3;

  always_ff @(posedge clk) begin
    if (rst) begin
      s1 <= 1'b0;
      s2 <= 1'b0;
      s3 <= 1'b0;
    end else begin
      s1 <= pin;
      s2 <= s1;
      s3 <= s2;
    end
  end

  // Only a stable value is taken over
  always_ff @(posedge clk) begin
    if (rst) begin
      level <= 1'b0;
    end else if (s2 == s3) begin
      level <= s3;
    end
  end
endmodule : mes_pin_sync

// file: rtl/mes_event_status.sv
// MAC event status, interrupt enable and summary with AXI4-Lite slave
// Functional notes
// - Writing a one to a flag position clears that flag, and only software writes or reset clear flags.
// - Writing a zero to a flag position leaves that flag as it was.
// - Interrupts from the status register show as one summary bit of the DMA-side status.
// - Every flag has its own enable bit at the same position in the enable register.
// - Enable one passes its flag, zero blocks it, at bits 4, 2, 1 and 0.
// - With flow control on, a PAUSE retry overflow sets the flag at bit 4.
// - Any toggle of the PHY link-status input sets the link change flag at bit 2.
// - A detected Magic Packet sets the flag at bit 1.
// - An illegal carrier reported by the PHY sets the flag at bit 0.
// - Bits 31 to 5 and bit 3 of both registers read as zero and ignore writes.
`timescale 1ns/1ns
module mes_event_status
  import mes_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire mes_events_t events_in,
  output logic             irq
);
  logic        pause_retry_overflow_flag;
  logic        link_change_flag;
  logic        magic_packet_flag;
  logic        illegal_carrier_flag;
  logic [31:0] mac_event_irq_enable;
  logic        flow_ctrl_en;
  logic        mac_event_summary;
  logic [31:0] mac_event_status;
  logic [31:0] dma_event_status;
  logic        phy_link_status_in;
  logic        carrier_level;
  logic        link_prev;
  logic        carrier_prev;
  logic        link_toggle;
  logic        carrier_rise;
  logic        pause_rise;
  logic        magic_rise;
  logic        pause_prev;
  logic        magic_prev;
  logic        aw_held;
  logic        w_held;
  logic [7:0]  aw_addr;
  logic [31:0] w_data;
  logic [3:0]  w_strb;
  logic        wr_fire;
  logic [31:0] wr_bits;
  logic        wr_status;
  logic        wr_enable;
  logic        wr_ctrl;
  logic        wr_known;
  logic [31:0] next_rdata;
  logic        rd_known;

  mes_pin_sync u_link_sync (
    .clk   (clk),
    .rst   (rst),
    .pin   (events_in.link_status),
    .level (phy_link_status_in)
  );

  mes_pin_sync u_carrier_sync (
    .clk   (clk),
    .rst   (rst),
    .pin   (events_in.illegal_carrier),
    .level (carrier_level)
  );

  // Event edges; pause and magic come from on-chip logic on the same clock
  always_ff @(posedge clk) begin
    if (rst) begin
      link_prev    <= 1'b0;
      carrier_prev <= 1'b0;
      pause_prev   <= 1'b0;
      magic_prev   <= 1'b0;
    end else begin
      link_prev    <= phy_link_status_in;
      carrier_prev <= carrier_level;
      pause_prev   <= events_in.pause_retry_over;
      magic_prev   <= events_in.magic_packet;
    end
  end

  // Link level before first sample is taken as low, so a link up after reset is reported
  assign link_toggle  = phy_link_status_in ^ link_prev;
  assign carrier_rise = carrier_level & ~carrier_prev;
  assign pause_rise   = events_in.pause_retry_over & ~pause_prev & flow_ctrl_en;
  assign magic_rise   = events_in.magic_packet & ~magic_prev;

  // Write channel: address and data taken in either order
  assign s_axi_awready = ~aw_held & ~s_axi_bvalid;
  assign s_axi_wready  = ~w_held & ~s_axi_bvalid;

  always_ff @(posedge clk) begin
    if (rst) begin
      aw_held <= 1'b0;
      aw_addr <= 8'h00;
    end else if (wr_fire) begin
      aw_held <= 1'b0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held <= 1'b1;
      aw_addr <= s_axi_awaddr;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      w_held <= 1'b0;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
    end else if (wr_fire) begin
      w_held <= 1'b0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held <= 1'b1;
      w_data <= s_axi_wdata;
      w_strb <= s_axi_wstrb;
    end
  end

  assign wr_fire   = aw_held & w_held;
  // Only byte lane 0 holds defined bits
  assign wr_bits   = w_strb[0] ? (w_data & MES_FIELD_MASK) : 32'h0000_0000;
  assign wr_status = wr_fire && (aw_addr[7:2] == MES_STATUS_OFFSET[7:2]);
  assign wr_enable = wr_fire && (aw_addr[7:2] == MES_ENABLE_OFFSET[7:2]);
  assign wr_ctrl   = wr_fire && (aw_addr[7:2] == MES_CTRL_OFFSET[7:2]);
  assign wr_known  = wr_status | wr_enable | wr_ctrl
                   | (aw_addr[7:2] == MES_DMA_OFFSET[7:2]);

  always_ff @(posedge clk) begin
    if (rst) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= MES_RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wr_known ? MES_RESP_OKAY : MES_RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Sticky flags: an event in the clearing cycle wins over the clear
  always_ff @(posedge clk) begin
    if (rst) begin
      pause_retry_overflow_flag <= 1'b0;
    end else if (pause_rise) begin
      pause_retry_overflow_flag <= 1'b1;
    end else if (wr_status && wr_bits[MES_PAUSE_BIT]) begin
      pause_retry_overflow_flag <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      link_change_flag <= 1'b0;
    end else if (link_toggle) begin
      link_change_flag <= 1'b1;
    end else if (wr_status && wr_bits[MES_LINK_BIT]) begin
      link_change_flag <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      magic_packet_flag <= 1'b0;
    end else if (magic_rise) begin
      magic_packet_flag <= 1'b1;
    end else if (wr_status && wr_bits[MES_MAGIC_BIT]) begin
      magic_packet_flag <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      illegal_carrier_flag <= 1'b0;
    end else if (carrier_rise) begin
      illegal_carrier_flag <= 1'b1;
    end else if (wr_status && wr_bits[MES_CARRIER_BIT]) begin
      illegal_carrier_flag <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      mac_event_irq_enable <= MES_RESET_VALUE;
    end else if (wr_enable) begin
      mac_event_irq_enable <= wr_bits;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      flow_ctrl_en <= 1'b0;
    end else if (wr_ctrl && w_strb[0]) begin
      flow_ctrl_en <= w_data[MES_FLOW_EN_BIT];
    end
  end

  always_comb begin
    mac_event_status = 32'h0000_0000;
    mac_event_status[MES_PAUSE_BIT]   = pause_retry_overflow_flag;
    mac_event_status[MES_LINK_BIT]    = link_change_flag;
    mac_event_status[MES_MAGIC_BIT]   = magic_packet_flag;
    mac_event_status[MES_CARRIER_BIT] = illegal_carrier_flag;
  end

  assign mac_event_summary = |(mac_event_status & mac_event_irq_enable);

  always_comb begin
    dma_event_status = 32'h0000_0000;
    dma_event_status[MES_SUMMARY_BIT] = mac_event_summary;
  end

  // Registered so the interrupt line is glitch free
  always_ff @(posedge clk) begin
    if (rst) begin
      irq <= 1'b0;
    end else begin
      irq <= mac_event_summary;
    end
  end

  // Read channel
  assign s_axi_arready = ~s_axi_rvalid;

  always_comb begin
    next_rdata = 32'h0000_0000;
    rd_known   = 1'b1;
    unique case (s_axi_araddr[7:2])
      MES_STATUS_OFFSET[7:2]: next_rdata = mac_event_status;
      MES_ENABLE_OFFSET[7:2]: next_rdata = mac_event_irq_enable;
      MES_DMA_OFFSET[7:2]:    next_rdata = dma_event_status;
      MES_CTRL_OFFSET[7:2]: begin
        next_rdata[MES_FLOW_EN_BIT] = flow_ctrl_en;
      end
      default:                rd_known = 1'b0;
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= MES_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= next_rdata;
      s_axi_rresp  <= rd_known ? MES_RESP_OKAY : MES_RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end
endmodule : mes_event_status

// file: bench/mes_props.sv
// Checker: bus and interrupt properties of the MAC event status block
`timescale 1ns/1ns
module mes_props
  import mes_pkg::*;
(
  input wire logic        clk,
  input wire logic        rst,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [7:0]  s_axi_araddr,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic        irq
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  sequence s_wr_take;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_rd_take;
    s_axi_arvalid && s_axi_arready;
  endsequence
  a_write_answer: assert property (s_wr_take |=> ##1 s_axi_bvalid)
    else $error("write response late");
  a_read_answer: assert property (s_rd_take |=> s_axi_rvalid)
    else $error("read response late");
  a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  a_aw_block: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write accepted while response pending");
  a_ar_block: assert property (s_axi_arready != s_axi_rvalid)
    else $error("read ready wrong");
  a_unmapped_err: assert property (s_rd_take ##0 (s_axi_araddr >= 8'h10) |=>
    s_axi_rresp == MES_RESP_SLVERR && s_axi_rdata == 32'h0)
    else $error("unmapped read not refused");
  a_reserved_zero: assert property (s_axi_rvalid |->
    (s_axi_rdata & ~MES_FIELD_MASK) == 32'h0)
    else $error("reserved bits read nonzero");
  a_irq_reset: assert property (disable iff (1'b0) rst |=> !irq)
    else $error("interrupt high after reset");
  a_irq_fall_cause: assert property ($fell(irq) |-> s_axi_bvalid)
    else $error("interrupt fell without a write");
endmodule : mes_props
bind mes_event_status mes_props u_props (.clk, .rst, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
  .irq);

// file: bench/mes_phy_model.sv
// Partner: PHY pins and MAC-side event sources
`timescale 1ns/1ns
module mes_phy_model
  import mes_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire mes_events_t fire,
  output mes_events_t      ev
);
  logic [2:0] cnt;
  // Carrier pin held several cycles so the synchroniser filter can see it
  always_ff @(posedge clk) begin
    if (rst) begin
      ev <= '0;
      cnt <= 3'h0;
    end else begin
      ev.pause_retry_over <= fire.pause_retry_over;
      ev.magic_packet <= fire.magic_packet;
      if (fire.link_status) ev.link_status <= !ev.link_status;
      cnt <= fire.illegal_carrier ? 3'h6 : (cnt != 3'h0 ? cnt - 3'h1 : 3'h0);
      ev.illegal_carrier <= fire.illegal_carrier || cnt != 3'h0;
    end
  end
endmodule : mes_phy_model

// file: bench/testbench.sv
// Testbench: register accesses and event scenarios for the MAC event status block
`timescale 1ns/1ns
module testbench
  import mes_pkg::*;
;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic [7:0]  s_axi_awaddr = 8'h0, s_axi_araddr = 8'h0;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, m;
  logic [3:0]  s_axi_wstrb = 4'hf;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  mes_events_t fire = '0, events_in;
  int          bad_count = 0, num_checks = 0;
  always #50 clk = ~clk;
  mes_phy_model u_phy (.clk, .rst, .fire, .ev(events_in));
  mes_event_status DUT (.clk, .rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .events_in, .irq);
  task automatic end_sim();
    $display("checks=%0d mismatches=%0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : end_sim
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic wrc(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    for (int n = 0; n < 40; n++) begin
      @(posedge clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid && s_axi_bready) begin
        chk({30'h0, s_axi_bresp}, {30'h0, r});
        s_axi_bready <= 1'b0;
        return;
      end
      // Ready raised a cycle late so the response must stand
      if (s_axi_bvalid) s_axi_bready <= 1'b1;
    end
    bad_count++;
    end_sim();
  endtask : wrc
  task automatic rdc(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    for (int n = 0; n < 40; n++) begin
      @(posedge clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid && s_axi_rready) begin
        chk(s_axi_rdata, d);
        chk({30'h0, s_axi_rresp}, {30'h0, r});
        s_axi_rready <= 1'b0;
        return;
      end
      if (s_axi_rvalid) s_axi_rready <= 1'b1;
    end
    bad_count++;
    end_sim();
  endtask : rdc
  task automatic fe(input mes_events_t f);
    fire <= f;
    @(posedge clk);
    fire <= '0;
    repeat (12) @(posedge clk);
  endtask : fe
  initial begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    rdc(MES_STATUS_OFFSET, 32'h0, MES_RESP_OKAY);
    rdc(MES_ENABLE_OFFSET, 32'h0, MES_RESP_OKAY);
    wrc(MES_ENABLE_OFFSET, 32'h17, MES_RESP_OKAY);
    rdc(MES_ENABLE_OFFSET, 32'h17, MES_RESP_OKAY);
    // Pass 0 link rises with flow control off, pass 1 link falls with it on
    for (int p = 0; p < 2; p++) begin
      wrc(MES_CTRL_OFFSET, 32'(p), MES_RESP_OKAY);
      rdc(MES_CTRL_OFFSET, 32'(p), MES_RESP_OKAY);
      for (int i = 0; i < 4; i++) begin
        m = 32'h1 << (i == 0 ? 4 : 3 - i);
        if (i == 0 && p == 0) m = 32'h0;
        wrc(MES_ENABLE_OFFSET, 32'h0, MES_RESP_OKAY);
        fe(mes_events_t'(4'h8 >> i));
        rdc(MES_STATUS_OFFSET, m, MES_RESP_OKAY);
        chk({31'h0, irq}, 32'h0);
        wrc(MES_ENABLE_OFFSET, m, MES_RESP_OKAY);
        repeat (2) @(posedge clk);
        chk({31'h0, irq}, {31'h0, m != 32'h0});
        rdc(MES_DMA_OFFSET, {31'h0, m != 32'h0}, MES_RESP_OKAY);
        wrc(MES_STATUS_OFFSET, 32'h17, MES_RESP_OKAY);
        rdc(MES_STATUS_OFFSET, 32'h0, MES_RESP_OKAY);
      end
    end
    fe(mes_events_t'(4'h2));
    wrc(MES_STATUS_OFFSET, 32'h15, MES_RESP_OKAY);
    rdc(MES_STATUS_OFFSET, 32'h2, MES_RESP_OKAY);
    wrc(8'h20, 32'h0, MES_RESP_SLVERR);
    rdc(8'h10, 32'h0, MES_RESP_SLVERR);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    rdc(MES_STATUS_OFFSET, 32'h0, MES_RESP_OKAY);
    rdc(MES_ENABLE_OFFSET, 32'h0, MES_RESP_OKAY);
    end_sim();
  end
endmodule : testbench
